// >>> hdl/cpu_addressing_prebyte_decoder.sv
// instruction fetch, prebyte handling and effective-address decode
// Notes on behaviour
// - short indexed: one offset byte plus index, unsigned, reach up to 1FE
// - long indexed: two-byte offset, whole 64 Kbyte space
// - indirect: byte after opcode addresses a pointer read before operand
// - short indirect: byte pointer address and byte pointer, range 00..FF
// - long indirect forms: byte pointer address, 16-bit pointer fetched
// - indirect indexed: index plus fetched pointer, unsigned
// - short indirect indexed: byte pointer plus index, range 00..1FE
// - read-modify-write, bit, call, jp short only; load/alu also long
// - relative: signed 8-bit offset added to address of next instruction
// - direct relative offset follows opcode; indirect offset read from memory
// - instructions are one to four bytes: prebyte, opcode, address bytes
// - prebyte only alters the opcode that immediately follows it
// - prebyte 90 swaps first index register for second one
// - prebyte 92 turns direct forms and X offset-indexed forms (not no-offset ones) into indirect
// - prebyte 91 turns X indirect indexed into second-index form
// - code neither opcode nor prebyte raises reset
// - valid prebyte with valid opcode never raises reset
// - 63 instruction types in 13 classes
// - conditional jumps test one flag, the C and Z pair, or the external line for either level
// - unsigned less on C, greater-equal on not C, greater on C and Z clear
// - bit test-and-jump reads byte, branches on selected bit level
// - indexed address is index plus offset; no offset gives 00..FF
// - short direct one byte page zero; long direct two bytes
`timescale 1ns/1ps
module cpu_addressing_prebyte_decoder
  import decoder_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // program/data memory
  output logic [15:0] memAddr,
  output logic memRd,
  input wire logic [7:0] memData,
  // datapath state
  input wire logic [7:0] idxX,
  input wire logic [7:0] idxY,
  input wire logic ccH,
  input wire logic ccI,
  input wire logic ccN,
  input wire logic ccZ,
  input wire logic ccC,
  input wire logic extIrqLine,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  input wire logic execDone,
  // decode results
  output logic decValid,
  output logic [7:0] decOpcode,
  output decoder_pkg::class_type decClass,
  output logic decUseY,
  output logic decIndirect,
  output logic [15:0] effAddr,
  output logic [15:0] pcNext,
  output logic branchTaken,
  output logic illegalRst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import decoder_pkg::*;

  typedef enum {
    ST_IDLE, ST_OP_RD, ST_OP_DAT, ST_DECODE, ST_ARG_RD, ST_ARG_DAT, ST_ADDR,
    ST_PTR_RD, ST_PTR_DAT, ST_PTR_DONE, ST_OPND_RD, ST_OPND_DAT, ST_DONE,
    ST_HOLD, ST_TRAPPED
  } state_type;

  state_type state_ff;
  logic [15:0] pc_ff;
  logic [7:0] opcode_ff;
  logic [7:0] prefix_ff;
  logic [15:0] args_ff;
  logic [15:0] ptr_ff;
  logic [7:0] opnd_ff;
  logic [1:0] argLeft_ff;
  logic [1:0] ptrLeft_ff;
  logic [2:0] byteCnt_ff;
  logic [15:0] memAddr_ff;
  logic memRd_ff;
  logic decValid_ff;
  logic [7:0] decOpcode_ff;
  class_type decClass_ff;
  logic decUseY_ff;
  logic decIndirect_ff;
  logic [15:0] effAddr_ff;
  logic [15:0] pcNext_ff;
  logic branchTaken_ff;
  logic illegalRst_ff;
  logic [7:0] ctrl_ff;
  logic illSeen_ff;
  logic [7:0] regRdData_ff;

  logic [3:0] mode;
  logic [3:0] low;
  logic p90;
  logic p91;
  logic p92;
  logic ind;
  logic useY;
  logic longPtr;
  logic indexed;
  logic [1:0] argCount;
  logic [7:0] firstArg;
  logic [7:0] idxSel;
  logic [15:0] eaBase;
  logic [15:0] eaCalc;
  logic [7:0] relOff;
  logic [15:0] target;
  logic condMet;
  logic isRel;
  logic isAbs;
  logic taken;
  logic [15:0] pcNextCalc;
  logic newIsPre;
  logic newDefined;
  logic illegalEvt;

  function automatic logic isPrebyte(input logic [7:0] b);
    return b == PRE_SECOND_INDEX || b == PRE_SECOND_INDEX_INDIRECT || b == PRE_INDIRECT;
  endfunction

  // short-only codes exist only in short modes, long forms only for load/alu
  function automatic logic opDefined(input logic [7:0] op);
    case (op[7:4])
      M_BITREL, M_BIT, M_REL: return 1'b1;
      M_SDIR, M_SIDX, M_NIDX: return op[3:0] <= SOP_LAST;
      M_INH_A, M_INH_X: return op[3:0] <= SOP_LAST && op[3:0] != SOP_CALL && op[3:0] != SOP_JP;
      M_MISC: return op[3:0] <= MISC_CALL_RELATIVE;
      M_PRE: return 1'b0;
      default: return op[3:0] <= ALU_LAST;
    endcase
  endfunction

  // thirteen classes over the sixty-three types
  function automatic class_type opClass(input logic [7:0] op);
    case (op[7:4])
      M_BITREL: return CLS_BTJ;
      M_BIT: return CLS_BIT;
      M_REL: return (op[3:0] <= COND_NEVER) ? CLS_JUMP : CLS_BRANCH;
      M_MISC: begin
        case (op[3:0])
          4'h1, 4'h2, 4'h3, 4'h5: return CLS_INT;
          4'h6, 4'h7, 4'h8, 4'h9: return CLS_FLAG;
          4'hA, 4'hC, 4'hD: return CLS_STACK;
          4'hB: return CLS_ARITH;
          default: return CLS_JUMP;
        endcase
      end
      M_SDIR, M_SIDX, M_NIDX, M_INH_A, M_INH_X: begin
        case (op[3:0])
          4'h0: return CLS_LOAD;
          4'h1, 4'h2: return CLS_INCDEC;
          4'h3: return CLS_CMP;
          4'h4, 4'h5: return CLS_LOGIC;
          SOP_CALL, SOP_JP: return CLS_JUMP;
          default: return CLS_SHIFT;
        endcase
      end
      default: begin
        case (op[3:0])
          4'h0: return CLS_LOAD;
          4'h1, 4'h9: return CLS_CMP;
          4'h2, 4'h3, 4'h4: return CLS_LOGIC;
          default: return CLS_ARITH;
        endcase
      end
    endcase
  endfunction

  // prebyte interpretation of the held opcode
  always_comb begin
    mode = opcode_ff[7:4];
    low = opcode_ff[3:0];
    p90 = prefix_ff == PRE_SECOND_INDEX;
    p91 = prefix_ff == PRE_SECOND_INDEX_INDIRECT;
    p92 = prefix_ff == PRE_INDIRECT;
    case (mode)
      M_BITREL, M_BIT, M_REL, M_SDIR, M_ADIR_S, M_ADIR_L: ind = p92;
      M_SIDX, M_AIDX_L, M_AIDX_S: ind = p92 || p91;
      M_MISC: ind = p92 && low == MISC_CALL_RELATIVE;
      default: ind = 1'b0;
    endcase
    case (mode)
      M_INH_X, M_NIDX, M_AIDX_N: useY = p90;
      M_SIDX, M_AIDX_L, M_AIDX_S: useY = p90 || p91;
      default: useY = 1'b0;
    endcase
    longPtr = ind && (mode == M_ADIR_L || mode == M_AIDX_L);
    indexed = mode == M_SIDX || mode == M_NIDX || mode == M_AIDX_L
      || mode == M_AIDX_S || mode == M_AIDX_N;
    case (mode)
      M_BITREL: argCount = 2'd2;
      M_BIT, M_REL, M_SDIR, M_SIDX, M_IMM, M_ADIR_S, M_AIDX_S: argCount = 2'd1;
      M_ADIR_L, M_AIDX_L: argCount = ind ? 2'd1 : 2'd2;
      M_MISC: argCount = (low == MISC_CALL_RELATIVE) ? 2'd1 : 2'd0;
      default: argCount = 2'd0;
    endcase
  end

  // effective address and branch target
  always_comb begin
    firstArg = (argCount == 2'd2) ? args_ff[15:8] : args_ff[7:0];
    idxSel = useY ? idxY : idxX;
    if (ind) begin
      eaBase = longPtr ? ptr_ff : {8'h00, ptr_ff[7:0]};
    end else begin
      case (mode)
        M_ADIR_L, M_AIDX_L: eaBase = args_ff;
        M_NIDX, M_AIDX_N: eaBase = 16'h0000;
        M_IMM: eaBase = pc_ff - 16'h0001;
        default: eaBase = {8'h00, firstArg};
      endcase
    end
    // zero-extended sum, carry reaches the upper byte
    eaCalc = eaBase + (indexed ? {8'h00, idxSel} : 16'h0000);
    relOff = (mode != M_BITREL && ind) ? ptr_ff[7:0] : args_ff[7:0];
    target = pc_ff + {{8{relOff[7]}}, relOff};
    case (low)
      COND_ALWAYS: condMet = 1'b1;
      COND_NEVER: condMet = 1'b0;
      COND_EQ: condMet = ccZ;
      COND_NE: condMet = !ccZ;
      COND_ULT: condMet = ccC;
      COND_UGE: condMet = !ccC;
      COND_MI: condMet = ccN;
      COND_PL: condMet = !ccN;
      COND_H: condMet = ccH;
      COND_NH: condMet = !ccH;
      COND_M: condMet = ccI;
      COND_NM: condMet = !ccI;
      COND_IH: condMet = extIrqLine;
      COND_IL: condMet = !extIrqLine;
      COND_UGT: condMet = !ccC && !ccZ;
      default: condMet = ccC || ccZ;
    endcase
    isRel = mode == M_REL || (mode == M_MISC && low == MISC_CALL_RELATIVE);
    isAbs = (mode == M_SDIR || mode == M_SIDX || mode == M_NIDX)
      && (low == SOP_CALL || low == SOP_JP);
    if (mode == M_REL) begin
      taken = condMet;
    end else if (mode == M_BITREL) begin
      taken = opnd_ff[low[3:1]] != low[0];
    end else begin
      taken = isRel || isAbs;
    end
    pcNextCalc = !taken ? pc_ff : ((isRel || mode == M_BITREL) ? target : eaCalc);
  end

  always_comb begin
    newIsPre = isPrebyte(memData);
    newDefined = opDefined(memData);
    illegalEvt = state_ff == ST_OP_DAT && !newIsPre && !newDefined && !pcLoad;
  end

  // fetch sequencer and memory port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      pc_ff <= PC_RST;
      opcode_ff <= 8'h00;
      prefix_ff <= PRE_NONE;
      args_ff <= 16'h0000;
      ptr_ff <= 16'h0000;
      opnd_ff <= 8'h00;
      argLeft_ff <= 2'd0;
      ptrLeft_ff <= 2'd0;
      byteCnt_ff <= 3'd0;
      memAddr_ff <= 16'h0000;
      memRd_ff <= 1'b0;
    end else begin
      memRd_ff <= 1'b0;
      if (pcLoad) begin
        pc_ff <= pcLoadValue;
        prefix_ff <= PRE_NONE;
        byteCnt_ff <= 3'd0;
        state_ff <= ST_IDLE;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (ctrl_ff[CTRL_RUN_BIT]) begin
              memAddr_ff <= pc_ff;
              memRd_ff <= 1'b1;
              pc_ff <= pc_ff + 16'h0001;
              byteCnt_ff <= 3'd1;
              state_ff <= ST_OP_RD;
            end
          end
          ST_OP_RD: state_ff <= ST_OP_DAT;
          ST_OP_DAT: begin
            if (newIsPre) begin
              // a repeated prebyte replaces the earlier one
              prefix_ff <= memData;
              memAddr_ff <= pc_ff;
              memRd_ff <= 1'b1;
              pc_ff <= pc_ff + 16'h0001;
              byteCnt_ff <= 3'd2;
              state_ff <= ST_OP_RD;
            end else if (!newDefined) begin
              prefix_ff <= PRE_NONE;
              state_ff <= ST_TRAPPED;
            end else begin
              opcode_ff <= memData;
              args_ff <= 16'h0000;
              ptr_ff <= 16'h0000;
              state_ff <= ST_DECODE;
            end
          end
          ST_DECODE: begin
            argLeft_ff <= argCount;
            if (argCount != 2'd0) begin
              memAddr_ff <= pc_ff;
              memRd_ff <= 1'b1;
              pc_ff <= pc_ff + 16'h0001;
              byteCnt_ff <= byteCnt_ff + 3'd1;
              state_ff <= ST_ARG_RD;
            end else begin
              state_ff <= ST_DONE;
            end
          end
          ST_ARG_RD: state_ff <= ST_ARG_DAT;
          ST_ARG_DAT: begin
            args_ff <= {args_ff[7:0], memData};
            argLeft_ff <= argLeft_ff - 2'd1;
            if (argLeft_ff > 2'd1) begin
              memAddr_ff <= pc_ff;
              memRd_ff <= 1'b1;
              pc_ff <= pc_ff + 16'h0001;
              byteCnt_ff <= byteCnt_ff + 3'd1;
              state_ff <= ST_ARG_RD;
            end else begin
              state_ff <= ST_ADDR;
            end
          end
          ST_ADDR: begin
            if (ind) begin
              memAddr_ff <= {8'h00, firstArg};
              memRd_ff <= 1'b1;
              ptrLeft_ff <= longPtr ? 2'd2 : 2'd1;
              state_ff <= ST_PTR_RD;
            end else if (mode == M_BITREL) begin
              memAddr_ff <= eaCalc;
              memRd_ff <= 1'b1;
              state_ff <= ST_OPND_RD;
            end else begin
              state_ff <= ST_DONE;
            end
          end
          ST_PTR_RD: state_ff <= ST_PTR_DAT;
          ST_PTR_DAT: begin
            // word pointers are read high byte first
            ptr_ff <= {ptr_ff[7:0], memData};
            ptrLeft_ff <= ptrLeft_ff - 2'd1;
            if (ptrLeft_ff == 2'd2) begin
              memAddr_ff <= {8'h00, firstArg} + 16'h0001;
              memRd_ff <= 1'b1;
              state_ff <= ST_PTR_RD;
            end else begin
              state_ff <= ST_PTR_DONE;
            end
          end
          ST_PTR_DONE: begin
            if (mode == M_BITREL) begin
              memAddr_ff <= eaCalc;
              memRd_ff <= 1'b1;
              state_ff <= ST_OPND_RD;
            end else begin
              state_ff <= ST_DONE;
            end
          end
          ST_OPND_RD: state_ff <= ST_OPND_DAT;
          ST_OPND_DAT: begin
            opnd_ff <= memData;
            state_ff <= ST_DONE;
          end
          ST_DONE: state_ff <= ST_HOLD;
          ST_HOLD: begin
            if (execDone) begin
              pc_ff <= pcNext_ff;
              prefix_ff <= PRE_NONE;
              byteCnt_ff <= 3'd0;
              state_ff <= ST_IDLE;
            end
          end
          ST_TRAPPED: state_ff <= ST_TRAPPED;
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // decode results and reset request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      decValid_ff <= 1'b0;
      decOpcode_ff <= 8'h00;
      decClass_ff <= CLS_LOAD;
      decUseY_ff <= 1'b0;
      decIndirect_ff <= 1'b0;
      effAddr_ff <= 16'h0000;
      pcNext_ff <= PC_RST;
      branchTaken_ff <= 1'b0;
      illegalRst_ff <= 1'b0;
    end else begin
      decValid_ff <= 1'b0;
      illegalRst_ff <= illegalEvt;
      if (state_ff == ST_DONE && !pcLoad) begin
        decValid_ff <= 1'b1;
        decOpcode_ff <= opcode_ff;
        decClass_ff <= opClass(opcode_ff);
        decUseY_ff <= useY;
        decIndirect_ff <= ind;
        effAddr_ff <= eaCalc;
        pcNext_ff <= pcNextCalc;
        branchTaken_ff <= taken;
      end
    end
  end

  // register port; a new illegal event wins over a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RST;
      illSeen_ff <= 1'b0;
      regRdData_ff <= 8'h00;
    end else begin
      if (regWr && regAddr == REG_CTRL) begin
        ctrl_ff <= regWrData;
      end
      if (illegalEvt) begin
        illSeen_ff <= 1'b1;
      end else if (regWr && regAddr == REG_STATUS && regWrData[STAT_ILL_BIT]) begin
        illSeen_ff <= 1'b0;
      end
      regRdData_ff <= 8'h00;
      if (regRd) begin
        case (regAddr)
          REG_CTRL: regRdData_ff <= ctrl_ff;
          REG_STATUS: begin
            regRdData_ff[STAT_BUSY_BIT] <= state_ff != ST_IDLE && state_ff != ST_TRAPPED;
            regRdData_ff[STAT_ILL_BIT] <= illSeen_ff;
          end
          REG_EA_LO: regRdData_ff <= effAddr_ff[7:0];
          REG_EA_HI: regRdData_ff <= effAddr_ff[15:8];
          REG_OPCODE: regRdData_ff <= decOpcode_ff;
          REG_PREFIX: regRdData_ff <= prefix_ff;
          default: regRdData_ff <= 8'h00;
        endcase
      end
    end
  end

  assign memAddr = memAddr_ff;
  assign memRd = memRd_ff;
  assign decValid = decValid_ff;
  assign decOpcode = decOpcode_ff;
  assign decClass = decClass_ff;
  assign decUseY = decUseY_ff;
  assign decIndirect = decIndirect_ff;
  assign effAddr = effAddr_ff;
  assign pcNext = pcNext_ff;
  assign branchTaken = branchTaken_ff;
  assign illegalRst = illegalRst_ff;
  assign regRdData = regRdData_ff;

  short_idx_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && mode == M_AIDX_S && !ind && !useY
      |-> eaCalc == {8'h00, args_ff[7:0]} + {8'h00, idxX})
    else $error("short indexed address wrong");
  long_idx_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && !pcLoad && mode == M_AIDX_L && !ind
      |=> effAddr_ff == $past(args_ff) + {8'h00, $past(idxSel)})
    else $error("long indexed address wrong");
  ptr_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_ADDR && ind && !pcLoad
      |=> memRd_ff && memAddr_ff[15:8] == 8'h00 ##1 state_ff == ST_PTR_DAT)
    else $error("pointer fetch not from page zero");
  short_ind_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && ind && (mode == M_SDIR || mode == M_ADIR_S) |-> eaCalc[15:8] == 8'h00)
    else $error("short indirect out of page zero");
  ind_idx_range_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && ind && (mode == M_SIDX || mode == M_AIDX_S) |-> eaCalc <= 16'h01FE)
    else $error("short indirect indexed beyond 1FE");
  rel_target_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && !pcLoad && mode == M_REL && !ind && condMet
      |=> branchTaken_ff && pcNext_ff == $past(pc_ff) + {{8{$past(relOff[7])}}, $past(relOff)})
    else $error("relative target wrong");
  instr_len_a: assert property (@(posedge clk) disable iff (!rstn)
    byteCnt_ff <= MAX_INSTR_BYTES)
    else $error("instruction longer than four bytes");
  second_idx_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && !pcLoad && prefix_ff == PRE_SECOND_INDEX && mode == M_AIDX_S
      |=> decUseY_ff)
    else $error("prebyte 90 did not select second index");
  illegal_rst_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_OP_DAT && !pcLoad && !isPrebyte(memData) && !opDefined(memData)
      |=> illegalRst_ff ##1 !illegalRst_ff)
    else $error("illegal code gave no single reset pulse");
  pre_legal_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_OP_DAT && prefix_ff != PRE_NONE && opDefined(memData) |=> !illegalRst_ff)
    else $error("prebyte pair raised reset");
  ugt_jump_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && !pcLoad && mode == M_REL && low == COND_UGT
      |=> branchTaken_ff == !($past(ccC) || $past(ccZ)))
    else $error("unsigned greater decision wrong");
  bit_jump_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == ST_DONE && mode == M_BITREL |-> taken == (opnd_ff[low[3:1]] ^ low[0]))
    else $error("bit test branch wrong");
  ill_nodec_a: assert property (@(posedge clk) disable iff (!rstn)
    illegalRst_ff |-> !decValid_ff && state_ff == ST_TRAPPED)
    else $error("illegal code reached decode output");
endmodule

// >>> hdl/decoder_pkg.sv
// package: encodings, register map and reset values of the addressing decoder
package decoder_pkg;
  // documented instruction-set size
  localparam int INSTR_TYPES = 63;
  localparam int CLASS_COUNT = 13;
  // prebytes
  localparam logic [7:0] PRE_NONE = 8'h00;
  localparam logic [7:0] PRE_SECOND_INDEX = 8'h90;
  localparam logic [7:0] PRE_SECOND_INDEX_INDIRECT = 8'h91;
  localparam logic [7:0] PRE_INDIRECT = 8'h92;
  // addressing mode, upper opcode nibble
  localparam logic [3:0] M_BITREL = 4'h0;
  localparam logic [3:0] M_BIT = 4'h1;
  localparam logic [3:0] M_REL = 4'h2;
  localparam logic [3:0] M_SDIR = 4'h3;
  localparam logic [3:0] M_INH_A = 4'h4;
  localparam logic [3:0] M_INH_X = 4'h5;
  localparam logic [3:0] M_SIDX = 4'h6;
  localparam logic [3:0] M_NIDX = 4'h7;
  localparam logic [3:0] M_MISC = 4'h8;
  localparam logic [3:0] M_PRE = 4'h9;
  localparam logic [3:0] M_IMM = 4'hA;
  localparam logic [3:0] M_ADIR_S = 4'hB;
  localparam logic [3:0] M_ADIR_L = 4'hC;
  localparam logic [3:0] M_AIDX_L = 4'hD;
  localparam logic [3:0] M_AIDX_S = 4'hE;
  localparam logic [3:0] M_AIDX_N = 4'hF;
  // short-only operations (lower nibble): 0 clr .. B swap, C call, D jp, E sla
  localparam logic [3:0] SOP_CALL = 4'hC;
  localparam logic [3:0] SOP_JP = 4'hD;
  localparam logic [3:0] SOP_LAST = 4'hE;
  // long/short operations: 0 ld .. 9 bit_compare
  localparam logic [3:0] ALU_LAST = 4'h9;
  // misc inherent: 0 nop .. D pop, E call_relative
  localparam logic [3:0] MISC_CALL_RELATIVE = 4'hE;
  // conditional_relative_jump conditions
  localparam logic [3:0] COND_ALWAYS = 4'h0;
  localparam logic [3:0] COND_NEVER = 4'h1;
  localparam logic [3:0] COND_EQ = 4'h2;
  localparam logic [3:0] COND_NE = 4'h3;
  localparam logic [3:0] COND_ULT = 4'h4;
  localparam logic [3:0] COND_UGE = 4'h5;
  localparam logic [3:0] COND_MI = 4'h6;
  localparam logic [3:0] COND_PL = 4'h7;
  localparam logic [3:0] COND_H = 4'h8;
  localparam logic [3:0] COND_NH = 4'h9;
  localparam logic [3:0] COND_M = 4'hA;
  localparam logic [3:0] COND_NM = 4'hB;
  localparam logic [3:0] COND_IH = 4'hC;
  localparam logic [3:0] COND_IL = 4'hD;
  localparam logic [3:0] COND_UGT = 4'hE;
  localparam logic [3:0] COND_ULE = 4'hF;
  // register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_EA_LO = 4'h2;
  localparam logic [3:0] REG_EA_HI = 4'h3;
  localparam logic [3:0] REG_OPCODE = 4'h4;
  localparam logic [3:0] REG_PREFIX = 4'h5;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILL_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [2:0] MAX_INSTR_BYTES = 3'd4;
  typedef enum logic [3:0] {
    CLS_LOAD, CLS_STACK, CLS_INCDEC, CLS_CMP, CLS_LOGIC, CLS_BIT, CLS_BTJ,
    CLS_ARITH, CLS_SHIFT, CLS_JUMP, CLS_BRANCH, CLS_INT, CLS_FLAG
  } class_type;
endpackage

// >>> test/mem_model.sv
// behavioural program and data memory feeding the decoder
`timescale 1ns/1ps
module mem_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  output logic [7:0] memData
);
  logic [7:0] mem [0:65535];
  initial begin
    memData = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h80;
  end
  // data stands one cycle only, then the inverse so stale bytes never match
  always @(posedge clk) memData <= memRd ? mem[memAddr] : ~memData;
endmodule

// >>> test/cpu_addressing_prebyte_decoder_tb.sv
// self-checking bench for the addressing and prebyte decoder
`timescale 1ns/1ps
module cpu_addressing_prebyte_decoder_tb;
  import decoder_pkg::*;
  logic clk = 0, rstn = 0, memRd, pcLoad = 0, execDone = 0, regWr = 0, regRd = 0;
  logic ccH = 0, ccI = 0, ccN = 0, ccZ = 0, ccC = 0, extIrqLine = 0;
  logic decValid, decUseY, decIndirect, branchTaken, illegalRst;
  logic [7:0] memData, idxX = 8'h00, idxY = 8'h00, regWrData = 8'h00, regRdData, rdv;
  logic [7:0] decOpcode;
  class_type decClass;
  logic [15:0] memAddr, pcLoadValue = 16'h0000, effAddr, pcNext;
  logic [3:0] regAddr = 4'h0;
  int miscompares = 0, n_tests = 0, cyc = 0;
  mem_model mem_model_i (.clk, .memAddr, .memRd, .memData);
  cpu_addressing_prebyte_decoder cpu_addressing_prebyte_decoder_i (.clk, .rstn, .memAddr,
    .memRd, .memData, .idxX, .idxY, .ccH, .ccI, .ccN, .ccZ, .ccC, .extIrqLine, .pcLoad,
    .pcLoadValue, .execDone, .decValid, .decOpcode, .decClass, .decUseY, .decIndirect,
    .effAddr, .pcNext, .branchTaken, .illegalRst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task ld(logic [15:0] a, logic [7:0] b0, logic [7:0] b1, logic [7:0] b2);
    mem_model_i.mem[a] = b0;
    mem_model_i.mem[a + 16'h0001] = b1;
    mem_model_i.mem[a + 16'h0002] = b2;
  endtask
  task waitDec;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (decValid !== 1'b1 && illegalRst !== 1'b1 && i < 80);
  endtask
  task run(logic [15:0] pc, logic [7:0] x, logic [7:0] y, logic ill, logic [15:0] ea,
           logic [15:0] np);
    @(posedge clk);
    pcLoad <= 1'b1;
    pcLoadValue <= pc;
    idxX <= x;
    idxY <= y;
    @(posedge clk);
    pcLoad <= 1'b0;
    waitDec();
    check("illegalRst", illegalRst, ill);
    if (!ill) begin
      check("effAddr", effAddr, ea);
      check("pcNext", pcNext, np);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdv = regRdData;
  endtask
  task tLong;
    ld(16'h0100, 8'hD0, 8'h12, 8'h34);
    run(16'h0100, 8'h05, 8'h00, 1'b0, 16'h1239, 16'h0103);
    @(posedge clk) execDone <= 1'b1;
    @(posedge clk) execDone <= 1'b0;
    waitDec();
    check("pcNext", pcNext, 16'h0104);
    check("decClass", decClass, CLS_JUMP);
    $display("long indexed done");
  endtask
  task tShort;
    ld(16'h0200, 8'hE0, 8'hFF, 8'h80);
    run(16'h0200, 8'hFF, 8'h00, 1'b0, 16'h01FE, 16'h0202);
    ld(16'h0300, PRE_SECOND_INDEX, 8'hE0, 8'h10);
    run(16'h0300, 8'h00, 8'hF0, 1'b0, 16'h0100, 16'h0303);
    check("decUseY", decUseY, 16'h0001);
    check("decOpcode", decOpcode, 16'h00E0);
    $display("short indexed done");
  endtask
  task tIndirect;
    ld(16'h0400, PRE_INDIRECT, 8'hB0, 8'h20);
    mem_model_i.mem[16'h0020] = 8'h77;
    run(16'h0400, 8'h00, 8'h00, 1'b0, 16'h0077, 16'h0403);
    check("decIndirect", decIndirect, 16'h0001);
    ld(16'h0500, PRE_SECOND_INDEX_INDIRECT, 8'hB0, 8'h30);
    run(16'h0500, 8'h00, 8'h00, 1'b0, 16'h0030, 16'h0503);
    ld(16'h0A00, PRE_INDIRECT, 8'hE0, 8'h20);
    run(16'h0A00, 8'hF0, 8'h00, 1'b0, 16'h0167, 16'h0A03);
    mem_model_i.mem[16'h0A00] = PRE_SECOND_INDEX_INDIRECT;
    run(16'h0A00, 8'h00, 8'hFF, 1'b0, 16'h0176, 16'h0A03);
    check("decUseY", decUseY, 16'h0001);
    $display("indirect done");
  endtask
  task tBranch;
    ld(16'h0600, 8'h2E, 8'hFE, 8'h80);
    run(16'h0600, 8'h00, 8'h00, 1'b0, 16'h00FE, 16'h0600);
    check("branchTaken", branchTaken, 16'h0001);
    @(posedge clk) ccZ <= 1'b1;
    run(16'h0600, 8'h00, 8'h00, 1'b0, 16'h00FE, 16'h0602);
    check("branchTaken", branchTaken, 16'h0000);
    ld(16'h0800, 8'h06, 8'h40, 8'h05);
    mem_model_i.mem[16'h0040] = 8'h08;
    run(16'h0800, 8'h00, 8'h00, 1'b0, 16'h0040, 16'h0808);
    check("branchTaken", branchTaken, 16'h0001);
    mem_model_i.mem[16'h0800] = 8'h07;
    run(16'h0800, 8'h00, 8'h00, 1'b0, 16'h0040, 16'h0803);
    check("branchTaken", branchTaken, 16'h0000);
    $display("branch done");
  endtask
  task tIllegal;
    ld(16'h0700, 8'h9F, 8'h80, 8'h80);
    run(16'h0700, 8'h00, 8'h00, 1'b1, 16'h0000, 16'h0000);
    rd(REG_STATUS);
    check("illSeen", {8'h00, rdv & 8'h02}, 16'h0002);
    wr(REG_STATUS, 8'h02);
    rd(REG_STATUS);
    check("illSeen", {8'h00, rdv & 8'h02}, 16'h0000);
    rd(4'hF);
    check("unmapped", {8'h00, rdv}, 16'h0000);
    $display("illegal code done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    tLong();
    tShort();
    tIndirect();
    tBranch();
    tIllegal();
    stop_test();
  end
endmodule
